// [pkg/pmrv_regs.vh]
/*
 * Register map constants for the transceiver management register view.
 * Assumes inclusion by the design file only; definitions only.
 */
`ifndef PMRV_REGS_VH
`define PMRV_REGS_VH

// ****************************************************************
// Register selects
// ****************************************************************
`define PMRV_REG_IDENT_UPPER 5'h02
`define PMRV_REG_IDENT_LOWER 5'h03
`define PMRV_REG_ADVERTISE 5'h04
`define PMRV_REG_PARTNER 5'h05
`define PMRV_REG_CABLE_DIAG 5'h1d
`define PMRV_REG_SPECIAL 5'h1f

// ****************************************************************
// Transceiver selects
// ****************************************************************
`define PMRV_PORT1_SEL 5'h01
`define PMRV_PORT2_SEL 5'h02

// ****************************************************************
// Field positions
// ****************************************************************
`define PMRV_ADV_PAUSE_BIT 10
`define PMRV_ADV_MODES_HI 8
`define PMRV_ADV_MODES_LO 5
`define PMRV_SEL_FIELD_HI 4
`define PMRV_DIAG_EN_BIT 15
`define PMRV_DIAG_RES_HI 14
`define PMRV_DIAG_RES_LO 13
`define PMRV_DIAG_SHORT_BIT 12
`define PMRV_DIAG_DIST_HI 8
`define PMRV_SPC_POLRV_BIT 5
`define PMRV_SPC_MDIX_BIT 4
`define PMRV_SPC_FLINK_BIT 3
`define PMRV_SPC_PSAVE_BIT 2
`define PMRV_SPC_RLOOP_BIT 1
`define PMRV_SPC_RSVD_BIT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define PMRV_ADV_PAUSE_RST 1'b1
`define PMRV_ADV_MODES_RST 4'hf
`define PMRV_SEL_FIELD_VAL 5'h01
`define PMRV_SPC_CTRL_RST 4'h4
`define PMRV_DIAG_RES_OPEN 2'h1
`define PMRV_DIAG_RES_FAIL 2'h3

`endif

// [verilog/pmrv_phy_regs.v]
/*
 * Management register view of the two copper transceivers: identifier,
 * advertisement, partner ability, cable diagnostic and special control.
 * Each port keeps its own copy of every writable field; the identifier
 * halves are fixed words shared by both ports. Control fields leave the
 * block as registered pins, one copy per port, so the transceivers see a
 * new setting on the edge after the write.
 * Reads return a registered word with a one-cycle valid pulse; writes
 * have no answer and land on the next edge.
 * Assumes a management front end that presents one-cycle read/write strobes
 * with transceiver and register selects; the analog side supplies status.
 * Status inputs are taken as synchronous to mclk. The cable test engine
 * raises done while the start level is up, and its outcome fields are
 * valid in that cycle only.
 */
// Notes on behaviour
// - Identifier readable as two read-only halves.
// - Pause advertise bit 10, writable, resets one.
// - Four mode advertise bits 8..5, reset one.
// - Partner pause reported read-only at bit 10.
// - Partner mode abilities reported at bits 8..5.
// - Write one starts cable test; self-clears.
// - Test outcome in bits 14..13, read-only.
// - Near short flag at bit 12.
// - Nine-bit fault distance at bits 8..0.
// - Polarity reversed shown at bit 5.
// - Power save bit 2, inverted, resets one.
// - Bit 1 enables per-port remote loopback.
`include "pmrv_regs.vh"

module pmrv_phy_regs #(
    parameter [15:0] IDENT_UPPER = 16'h1234, // Arbitrary value
    parameter [15:0] IDENT_LOWER = 16'h5678  // Arbitrary value
) (
    input wire mclk,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [4:0] transceiver_select,
    input wire [4:0] register_select,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output reg reg_rvalid,
    input wire [1:0] partner_pause,
    input wire [7:0] partner_modes,
    input wire [1:0] diag_done,
    input wire [3:0] diag_result,
    input wire [1:0] diag_near_short,
    input wire [17:0] diag_distance,
    input wire [1:0] polarity_reversed,
    input wire [1:0] mdix_state,
    output wire [1:0] adv_pause,
    output wire [7:0] adv_modes,
    output wire [1:0] diag_start,
    output wire [1:0] force_link,
    output wire [1:0] power_save_off,
    output wire [1:0] remote_loopback,
    output wire [1:0] special_reserved
);

    // ****************************************************************
    // Port decode codes
    // ****************************************************************
    // Bit 1 marks a present port, bit 0 picks which one
    localparam [1:0] PORT_ABSENT = 2'b00;
    localparam [1:0] PORT_FIRST = 2'b10;
    localparam [1:0] PORT_SECOND = 2'b11;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // Port index from transceiver select
    function [1:0] pmrv_port;
        input [4:0] sel;
        begin
            case (sel)
                `PMRV_PORT1_SEL: pmrv_port = PORT_FIRST;
                `PMRV_PORT2_SEL: pmrv_port = PORT_SECOND;
                default: pmrv_port = PORT_ABSENT;
            endcase
        end
    endfunction

    // Write strobe aimed at one register of the addressed port
    function pmrv_wr_hit;
        input wr;
        input port_hit;
        input [4:0] sel;
        input [4:0] target;
        begin
            pmrv_wr_hit = wr && port_hit && (sel == target);
        end
    endfunction

    // Pause and mode abilities placed in a clear word; the advertised
    // view and the partner's view share one layout
    function [15:0] pmrv_mode_word;
        input pause;
        input [3:0] modes;
        begin
            pmrv_mode_word = 16'h0000;
            pmrv_mode_word[`PMRV_ADV_PAUSE_BIT] = pause;
            pmrv_mode_word[`PMRV_ADV_MODES_HI:`PMRV_ADV_MODES_LO] = modes;
        end
    endfunction

    // ****************************************************************
    // Port select
    // ****************************************************************
    // Decoded once, shared by the write strobes and the read return
    wire [1:0] port_dec;
    assign port_dec = pmrv_port(transceiver_select);
    wire port_present;
    wire port_index;
    assign port_present = port_dec[1];
    assign port_index = port_dec[0];

    // Read mux data per port, gathered for the output register
    wire [15:0] rd_word [0:1];

    // Word returned to the station; absent transceiver reads zero
    wire [15:0] rd_sel_word;
    assign rd_sel_word = port_present ? rd_word[port_index] : 16'h0000;

    // ****************************************************************
    // Per-port register state
    // ****************************************************************
    // One copy of every field per port; the ports never interact
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_port
            // Stored fields of this port
            reg adv_pause_q;
            reg [3:0] adv_modes_q;
            reg diag_en_q;
            reg [1:0] diag_res_q;
            reg diag_short_q;
            reg [8:0] diag_dist_q;
            reg [3:0] spc_ctrl_q;
            // Read mux output and access strobes
            reg [15:0] rd_mux;
            wire hit;
            wire adv_wr;
            wire diag_wr;
            wire spc_wr;
            wire diag_wr_start;
            wire diag_finish;

            // ****************************************************************
            // Access decode for this port
            // ****************************************************************
            // Port match; an absent select never matches either port
            assign hit = port_present && (port_index == g);

            // One strobe per writable register keeps the write blocks short
            assign adv_wr = pmrv_wr_hit(reg_wr, hit, register_select, `PMRV_REG_ADVERTISE);
            assign diag_wr = pmrv_wr_hit(reg_wr, hit, register_select, `PMRV_REG_CABLE_DIAG);
            assign spc_wr = pmrv_wr_hit(reg_wr, hit, register_select, `PMRV_REG_SPECIAL);

            // Only a one in the enable bit launches; writing zero never aborts
            assign diag_wr_start = diag_wr && reg_wdata[`PMRV_DIAG_EN_BIT];
            // Completion counts only while a test is really running
            assign diag_finish = diag_en_q && diag_done[g];

            // ****************************************************************
            // Advertisement control
            // ****************************************************************
            // Pause offer; reserved and selector bits ignore writes
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    adv_pause_q <= `PMRV_ADV_PAUSE_RST;
                end else if (adv_wr) begin
                    adv_pause_q <= reg_wdata[`PMRV_ADV_PAUSE_BIT];
                end
            end

            // Four mode offers; all start set so every mode is offered
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    adv_modes_q <= `PMRV_ADV_MODES_RST;
                end else if (adv_wr) begin
                    adv_modes_q <= reg_wdata[`PMRV_ADV_MODES_HI:`PMRV_ADV_MODES_LO];
                end
            end

            // ****************************************************************
            // Cable diagnostic
            // ****************************************************************
            // Enable: set by a write of one, self-cleared on completion.
            // Completion wins over a same-cycle start so a finished test
            // is never reported as still running.
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    diag_en_q <= 1'b0;
                end else if (diag_finish) begin
                    diag_en_q <= 1'b0;
                end else if (diag_wr_start) begin
                    diag_en_q <= 1'b1;
                end
            end

            // Results latch at completion; the engine's outputs are only
            // valid then, and the station reads them long after
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    diag_res_q <= 2'h0;
                    diag_short_q <= 1'b0;
                    diag_dist_q <= 9'h000;
                end else if (diag_finish) begin
                    diag_res_q <= diag_result[2*g+1:2*g];
                    diag_short_q <= diag_near_short[g];
                    diag_dist_q <= diag_distance[9*g+8:9*g];
                end
            end

            // ****************************************************************
            // Special control
            // ****************************************************************
            // Control bits 3..0: force link, power save (inverted), remote
            // loopback and a reserved bit that is kept and driven out on special_reserved
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    spc_ctrl_q <= `PMRV_SPC_CTRL_RST;
                end else if (spc_wr) begin
                    spc_ctrl_q <= reg_wdata[`PMRV_SPC_FLINK_BIT:`PMRV_SPC_RSVD_BIT];
                end
            end

            // ****************************************************************
            // Read view
            // ****************************************************************
            // Unsupported fields are hard zero
            always @* begin
                rd_mux = 16'h0000;
                case (register_select)
                    `PMRV_REG_IDENT_UPPER: rd_mux = IDENT_UPPER;
                    `PMRV_REG_IDENT_LOWER: rd_mux = IDENT_LOWER;
                    `PMRV_REG_ADVERTISE: begin
                        rd_mux = pmrv_mode_word(adv_pause_q, adv_modes_q);
                        rd_mux[`PMRV_SEL_FIELD_HI:0] = `PMRV_SEL_FIELD_VAL;
                    end
                    `PMRV_REG_PARTNER: begin
                        rd_mux = pmrv_mode_word(partner_pause[g], partner_modes[4*g+3:4*g]);
                    end
                    `PMRV_REG_CABLE_DIAG: begin
                        rd_mux[`PMRV_DIAG_EN_BIT] = diag_en_q;
                        rd_mux[`PMRV_DIAG_RES_HI:`PMRV_DIAG_RES_LO] = diag_res_q;
                        rd_mux[`PMRV_DIAG_SHORT_BIT] = diag_short_q;
                        rd_mux[`PMRV_DIAG_DIST_HI:0] = diag_dist_q;
                    end
                    `PMRV_REG_SPECIAL: begin
                        rd_mux[`PMRV_SPC_POLRV_BIT] = polarity_reversed[g];
                        rd_mux[`PMRV_SPC_MDIX_BIT] = mdix_state[g];
                        rd_mux[`PMRV_SPC_FLINK_BIT:0] = spc_ctrl_q;
                    end
                    default: rd_mux = 16'h0000;
                endcase
            end

            assign rd_word[g] = rd_mux;

            // ****************************************************************
            // Control pins
            // ****************************************************************
            // Advertisement offers to the negotiation logic
            assign adv_pause[g] = adv_pause_q;
            assign adv_modes[4*g+3:4*g] = adv_modes_q;
            // Cable test request to the engine
            assign diag_start[g] = diag_en_q; // Level while test runs
            // Special controls; loopback stays within this one port
            assign force_link[g] = spc_ctrl_q[`PMRV_SPC_FLINK_BIT];
            assign power_save_off[g] = spc_ctrl_q[`PMRV_SPC_PSAVE_BIT];
            assign remote_loopback[g] = spc_ctrl_q[`PMRV_SPC_RLOOP_BIT];
            assign special_reserved[g] = spc_ctrl_q[`PMRV_SPC_RSVD_BIT];
        end
    endgenerate

    // ****************************************************************
    // Read return
    // ****************************************************************
    // Valid pulse one cycle after each read strobe
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // Read data held until the next read, so a slow station can
    // pick it up any time after the valid pulse
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_sel_word;
        end
    end

endmodule // pmrv_phy_regs

// [verif/pmrv_properties.sv]
/* Port checker for the transceiver register view.
   Assumes one clock and bind onto pmrv_phy_regs. */
module pmrv_properties #(
    parameter [15:0] IDENT_UPPER = 16'h1234
) (
    input wire mclk,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [4:0] transceiver_select,
    input wire [4:0] register_select,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire [1:0] diag_done,
    input wire [1:0] diag_start,
    input wire [1:0] adv_pause,
    input wire [7:0] adv_modes
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Access relations: port 1, plus unknown-port and any-port special reads
    // ****
    wire p1 = transceiver_select == 5'h01;
    wire [4:0] rs = register_select;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_ident_read: assert property (reg_rd && p1 && rs == 5'h02 |=> reg_rdata == IDENT_UPPER)
        else $error("identifier read wrong");
    a_unknown_port_zero: assert property (reg_rd && transceiver_select > 5'h02 |=> reg_rdata == 16'h0000)
        else $error("unknown port not zero");
    a_pause_write: assert property (reg_wr && p1 && rs == 5'h04 |=> adv_pause[0] == $past(reg_wdata[10]))
        else $error("pause control wrong");
    a_modes_write: assert property (reg_wr && p1 && rs == 5'h04 |=> adv_modes[3:0] == $past(reg_wdata[8:5]))
        else $error("mode controls wrong");
    a_diag_launch: assert property (reg_wr && p1 && rs == 5'h1d && reg_wdata[15] && !diag_start[0] |=> diag_start[0])
        else $error("test not launched");
    a_diag_self_clear: assert property (diag_start[0] && diag_done[0] |=> !diag_start[0])
        else $error("test bit not cleared");
    a_diag_holds_busy: assert property (diag_start[0] && !diag_done[0] |=> $stable(diag_start[0]))
        else $error("test ended early");
    a_special_upper_zero: assert property (reg_rd && rs == 5'h1f |=> reg_rdata[15:6] == 10'h000)
        else $error("reserved bits not zero");
    cover property (diag_start[0] && diag_done[0]);
    cover property (reg_wr && p1 && rs == 5'h1f);
    cover property (reg_rd && transceiver_select == 5'h03);
endmodule // pmrv_properties

bind pmrv_phy_regs pmrv_properties #(.IDENT_UPPER(IDENT_UPPER)) i_chk (.*);

// [verif/pmrv_diag_model.sv]
/* Far-side cable test engine, one per port.
   Assumes diag_start is a level held until done. */
module pmrv_diag_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] diag_start,
    input wire logic [7:0] wait_cyc,
    input wire logic [11:0] outcome,
    output wire [1:0] diag_done,
    output wire [3:0] diag_result,
    output wire [1:0] diag_near_short,
    output wire [17:0] diag_distance
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Per-port engine
    // ****
    for (genvar g = 0; g < 2; g++) begin : g_port
        logic [7:0] cnt_q;
        // Port 2 gets the inverse so a port swap shows
        wire [11:0] v = g ? ~outcome : outcome;
        // Wait set by the bench, so slow tests occur
        always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) cnt_q <= 8'h00;
            else cnt_q <= (diag_start[g] && !diag_done[g]) ? cnt_q + 8'h01 : 8'h00;
        end
        assign diag_done[g] = diag_start[g] && cnt_q == wait_cyc;
        // Outcome is junk outside the done cycle
        assign {diag_result[2*g+:2], diag_near_short[g], diag_distance[9*g+:9]} = diag_done[g] ? v : ~v;
    end
endmodule // pmrv_diag_model

// [verif/tb_top.sv]
/* Self-checking bench for the register view.
   Assumes pmrv_phy_regs, its checker and the test engine model. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, reg_rvalid;
    logic [4:0] transceiver_select = 0, register_select = 0;
    logic [15:0] reg_wdata = 0, reg_rdata;
    logic [1:0] partner_pause = 0, polarity_reversed = 0, mdix_state = 0, diag_done, diag_start, adv_pause;
    logic [1:0] force_link, power_save_off, remote_loopback, special_reserved, diag_near_short;
    logic [7:0] partner_modes = 0, adv_modes, wait_cyc = 8'h03;
    logic [3:0] diag_result;
    logic [17:0] diag_distance;
    logic [11:0] outcome = 0, dg[2] = '{12'h000, 12'h000};
    logic [15:0] adv[2] = '{16'h05e1, 16'h05e1}, spc[2] = '{16'h0004, 16'h0004};
    logic [4:0] regs[8] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h1d, 5'h1f, 5'h00, 5'h07};
    int errors = 0, cmp_count = 0;
    pmrv_phy_regs i_dut (.*);
    pmrv_diag_model i_far (.*);
    // ****
    // Checks and bus cycles
    // ****
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(logic w, logic [4:0] t, logic [4:0] r, logic [15:0] d);
        @(posedge mclk) {reg_wr, reg_rd, transceiver_select, register_select, reg_wdata} <= {w, !w, t, r, d};
        @(posedge mclk) {reg_wr, reg_rd} <= 2'b00;
        #1;
        chk("valid", {15'h0, reg_rvalid}, {15'h0, !w});
    endtask
    // Expected read word; diag only compared when idle
    function automatic logic [15:0] exp_rd(logic [4:0] t, logic [4:0] r);
        int i;
        i = t - 1;
        if (t != 5'h01 && t != 5'h02) return 16'h0000;
        case (r)
            5'h02: return 16'h1234; // Arbitrary identifier default
            5'h03: return 16'h5678; // Arbitrary identifier default
            5'h04: return adv[i];
            5'h05: return {5'h00, partner_pause[i], 1'b0, partner_modes[4*i+:4], 5'h00};
            5'h1d: return {1'b0, dg[i][11:9], 3'h0, dg[i][8:0]};
            5'h1f: return {10'h000, polarity_reversed[i], mdix_state[i], spc[i][3:0]};
            default: return 16'h0000;
        endcase
    endfunction
    task automatic report_and_stop();
        $display("errors %0d checks %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        forever #5 mclk = ~mclk;
    end
    // Watchdog well past the expected run of several hundred cycles
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        report_and_stop();
    end
    initial begin
        logic [4:0] t, r;
        logic [15:0] d, e;
        void'($urandom(1519));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        // Reset contents, unmapped places and an unknown port
        for (int k = 0; k < 24; k++) begin
            acc(1'b0, 5'(1 + k / 8), regs[k % 8], 16'h0000);
            chk("reset read", reg_rdata, exp_rd(5'(1 + k / 8), regs[k % 8]));
        end
        // Random writes anywhere, read back and pin view
        repeat (60) begin
            t = 5'(1 + $urandom % 3);
            r = regs[$urandom % 8];
            d = 16'($urandom) & 16'h7ffe;
            @(posedge mclk) {partner_pause, partner_modes, polarity_reversed, mdix_state} <= 14'($urandom);
            acc(1'b1, t, r, d);
            if (t < 3 && r == 5'h04) adv[t - 1] = (d & 16'h05e0) | 16'h0001;
            if (t < 3 && r == 5'h1f) spc[t - 1] = d & 16'h000f;
            acc(1'b0, t, r, 16'h0000);
            chk("readback", reg_rdata, exp_rd(t, r));
            e = {spc[1][3], spc[0][3], adv[1][10], adv[0][10], spc[1][2], spc[0][2], spc[1][1], spc[0][1], 8'h00};
            e[7:0] = {adv[1][8:5], adv[0][8:5]};
            chk("pins", {force_link, adv_pause, power_save_off, remote_loopback, adv_modes}, e);
            chk("reserved pin", {14'h0000, special_reserved}, {14'h0000, spc[1][0], spc[0][0]});
        end
        // Every outcome code on both ports, with varied test length
        for (int c = 0; c < 8; c++) begin
            t = 5'(1 + c % 2);
            @(posedge mclk) outcome <= {2'(c / 2), 10'($urandom)};
            wait_cyc <= 8'(3 + $urandom % 40);
            acc(1'b1, t, 5'h1d, 16'h8000);
            acc(1'b0, t, 5'h1d, 16'h0000);
            chk("busy", {15'h0, reg_rdata[15]}, 16'h0001);
            for (int n = 0; n < 60 && reg_rdata[15] !== 1'b0; n++) acc(1'b0, t, 5'h1d, 16'h0000);
            dg[t - 1] = t == 5'h02 ? ~outcome : outcome;
            chk("diag", reg_rdata, exp_rd(t, 5'h1d));
        end
        report_and_stop();
    end
endmodule // tb_top
